// ===== lsf_pkg.sv
/*
 Package for the backlight driver state and fault controller: register map,
 field positions, reset values, timing constants and the current table.
 Assumes a 25 MHz system clock.
*/
package lsf_pkg;
	localparam int          LSF_NSTR        = 5;
	localparam int          LSF_CLK_HZ      = 25000000;
	localparam int          LSF_DEB_MS      = 16;
	localparam int          LSF_DEB_CYC     = LSF_DEB_MS * (LSF_CLK_HZ / 1000);
	localparam int          LSF_SYNC_LEN    = 3;
	// Register offsets
	localparam logic [3:0]  LSF_A_ENABLE    = 4'h0;
	localparam logic [3:0]  LSF_A_LEVEL1    = 4'h1;
	localparam logic [3:0]  LSF_A_LEVEL2    = 4'h2;
	localparam logic [3:0]  LSF_A_STR_FLT   = 4'h3;
	localparam logic [3:0]  LSF_A_GLB_FLT   = 4'h4;
	localparam logic [3:0]  LSF_A_STATE     = 4'h5;
	localparam logic [3:0]  LSF_A_IRQ_STAT  = 4'h6;
	localparam logic [3:0]  LSF_A_IRQ_MASK  = 4'h7;
	localparam logic [3:0]  LSF_A_CUR1      = 4'h8;
	localparam logic [3:0]  LSF_A_CUR2      = 4'h9;
	// Global fault bit positions
	localparam int          LSF_B_OVP       = 0;
	localparam int          LSF_B_THERM     = 1;
	localparam int          LSF_B_DIODE     = 2;
	// Interrupt status bit positions
	localparam int          LSF_I_STR       = 0;
	localparam int          LSF_I_GLB       = 1;
	localparam int          LSF_I_RUN       = 2;
	// Reset values
	localparam logic [4:0]  LSF_RST_ENABLE  = 5'h00;
	localparam logic [6:0]  LSF_RST_LEVEL   = 7'h00;
	localparam logic [2:0]  LSF_RST_MASK    = 3'h0;

	typedef enum logic [1:0] {
		LSF_SHUTDOWN = 2'b00,
		LSF_STANDBY  = 2'b01,
		LSF_ON       = 2'b10
	} lsf_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} lsf_bus_t;

	typedef struct packed {
		logic [4:0] open_det;
		logic [4:0] short_det;
		logic       overvoltage_fault;
		logic       therm;
		logic       diode_open;
		logic       vdd_ok;
		logic       vin_ok;
	} lsf_sense_t;

	// Regulator current in units of 10 uA, one entry per level code
	localparam logic [11:0] LSF_CUR_TAB [128] = '{
		12'd5,    12'd10,   12'd20,   12'd25,   12'd35,   12'd45,   12'd55,   12'd65,
		12'd75,   12'd85,   12'd100,  12'd110,  12'd120,  12'd135,  12'd145,  12'd160,
		12'd175,  12'd185,  12'd200,  12'd215,  12'd230,  12'd245,  12'd260,  12'd275,
		12'd290,  12'd305,  12'd320,  12'd335,  12'd350,  12'd365,  12'd385,  12'd400,
		12'd415,  12'd435,  12'd455,  12'd470,  12'd490,  12'd505,  12'd525,  12'd545,
		12'd560,  12'd580,  12'd595,  12'd615,  12'd635,  12'd650,  12'd670,  12'd690,
		12'd710,  12'd730,  12'd745,  12'd765,  12'd785,  12'd805,  12'd825,  12'd845,
		12'd865,  12'd885,  12'd905,  12'd925,  12'd945,  12'd965,  12'd990,  12'd1010,
		12'd1030, 12'd1050, 12'd1070, 12'd1090, 12'd1115, 12'd1135, 12'd1155, 12'd1180,
		12'd1200, 12'd1220, 12'd1245, 12'd1265, 12'd1285, 12'd1310, 12'd1330, 12'd1355,
		12'd1375, 12'd1400, 12'd1420, 12'd1445, 12'd1465, 12'd1490, 12'd1515, 12'd1535,
		12'd1560, 12'd1580, 12'd1605, 12'd1630, 12'd1650, 12'd1675, 12'd1700, 12'd1725,
		12'd1745, 12'd1770, 12'd1795, 12'd1820, 12'd1845, 12'd1865, 12'd1890, 12'd1915,
		12'd1940, 12'd1965, 12'd1990, 12'd2015, 12'd2040, 12'd2065, 12'd2090, 12'd2115,
		12'd2140, 12'd2165, 12'd2190, 12'd2215, 12'd2240, 12'd2265, 12'd2290, 12'd2315,
		12'd2340, 12'd2370, 12'd2395, 12'd2420, 12'd2445, 12'd2470, 12'd2500, 12'd2525
	};
endpackage

// ===== lsf_ctrl.sv
/*
 State and fault controller of a five-string backlight LED driver.
 Assumes analog sense comparators arrive asynchronously and are
 synchronised here; the register port is driven on mclk.
*/
// Functional notes
// - 7-bit level code selects monotonic current, 0x00 is 0.05 mA, 0x7F 25.25 mA.
// - Leaving shutdown, soft-start begins once any string is enabled.
// - Interface supply low with valid input: shutdown, registers reset, outputs off.
// - Interface supply and input valid: standby, commands accepted, converter off.
// - From standby, converter turns on when any regulator is enabled.
// - Switch node and all five string outputs high impedance while converter off.
// - Each string has separate open and short detectors.
// - Fault held 16 ms is latched and its regulator disabled.
// - Reading string fault flags clears them and re-enables the strings.
// - Global fault clears enables; leave standby after its read and a new enable.
`timescale 1ns/1ps
module lsf_ctrl
	import lsf_pkg::*;
#(
	parameter int DEB_CYC = LSF_DEB_CYC
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	input  wire logic       clk_en,
	// Register port
	input  wire lsf_bus_t   bus,
	output logic [7:0]      rdata,
	// Analog sense inputs
	input  wire lsf_sense_t sense,
	// Power stage controls
	output logic            converter_on,
	output logic            soft_start,
	output logic [4:0]      string_on,
	output logic [4:0]      string_hiz,
	output logic            converter_switch_node_hiz,
	output logic [6:0]      level1,
	output logic [6:0]      level2,
	output logic [1:0]      power_state,
	output logic            irq
);

	localparam int SW = $bits(lsf_sense_t);
	localparam int DW = $clog2(DEB_CYC + 1);

	// Three stage synchroniser; only stages two and three are looked at
	logic [SW-1:0] s1;
	logic [SW-1:0] s2;
	logic [SW-1:0] s3;
	logic [SW-1:0] stable;
	lsf_sense_t    sn;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			stable <= '0;
		end else if (clk_en) begin
			s1 <= sense;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < SW; i++) begin
				if (s2[i] == s3[i]) begin
					stable[i] <= s3[i];
				end
			end
		end
	end
	assign sn = lsf_sense_t'(stable);

	// Registers
	lsf_state_t    state;
	logic [4:0]    enable;
	logic [6:0]    lvl1;
	logic [6:0]    lvl2;
	logic [4:0]    str_flt;
	logic [2:0]    glb_flt;
	logic [2:0]    irq_stat;
	logic [2:0]    irq_mask;
	logic [4:0]    deb_hit;

	wire supply_ok  = sn.vdd_ok & sn.vin_ok;
	wire wr_enable  = bus.wr && (bus.addr == LSF_A_ENABLE);
	wire wr_level1  = bus.wr && (bus.addr == LSF_A_LEVEL1);
	wire wr_level2  = bus.wr && (bus.addr == LSF_A_LEVEL2);
	wire wr_imask   = bus.wr && (bus.addr == LSF_A_IRQ_MASK);
	wire wr_istat   = bus.wr && (bus.addr == LSF_A_IRQ_STAT);
	wire rd_strflt  = bus.rd && (bus.addr == LSF_A_STR_FLT);
	wire rd_glbflt  = bus.rd && (bus.addr == LSF_A_GLB_FLT);
	wire [2:0] glb_ev = {sn.diode_open, sn.therm, sn.overvoltage_fault};
	wire glb_any    = |glb_ev;
	wire glb_block  = |glb_flt;
	wire [4:0] next_str_flt = (rd_strflt ? 5'h00 : str_flt) | deb_hit;

	// Debounce per string, open or short alike
	generate
		for (genvar g = 0; g < LSF_NSTR; g++) begin : g_deb
			logic [DW-1:0] cnt;
			wire flt = sn.open_det[g] | sn.short_det[g];
			always_ff @(posedge mclk) begin
				if (sys_rst || state != LSF_ON) begin
					cnt <= '0;
					deb_hit[g] <= 1'b0;
				end else if (clk_en) begin
					if (!flt || !enable[g]) begin
						cnt <= '0;
						deb_hit[g] <= 1'b0;
					end else if (cnt == DW'(DEB_CYC - 1)) begin
						cnt <= '0;
						deb_hit[g] <= 1'b1;
					end else begin
						cnt <= cnt + 1'b1;
						deb_hit[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	// Enables: string faults clear one bit, global faults all
	logic [4:0] next_enable;
	always_comb begin
		next_enable = enable;
		if (wr_enable && !glb_block) begin
			next_enable = bus.wdata[4:0];
		end
		if (rd_strflt) begin
			next_enable = next_enable | str_flt;
		end
		next_enable = next_enable & ~deb_hit;
		if (glb_any) begin
			next_enable = 5'h00;
		end
	end

	lsf_state_t next_state;
	always_comb begin
		case (state)
			LSF_SHUTDOWN: next_state = supply_ok ? LSF_STANDBY : LSF_SHUTDOWN;
			LSF_STANDBY:  next_state = (|enable && !glb_block) ? LSF_ON : LSF_STANDBY;
			LSF_ON:       next_state = (glb_any || ~|enable) ? LSF_STANDBY : LSF_ON;
			default:      next_state = LSF_SHUTDOWN;
		endcase
		if (!supply_ok) begin
			next_state = LSF_SHUTDOWN;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst || (clk_en && !supply_ok)) begin
			state <= LSF_SHUTDOWN;
			enable <= LSF_RST_ENABLE;
			lvl1 <= LSF_RST_LEVEL;
			lvl2 <= LSF_RST_LEVEL;
			str_flt <= '0;
			glb_flt <= '0;
			irq_stat <= '0;
			irq_mask <= LSF_RST_MASK;
		end else if (clk_en) begin
			state <= next_state;
			enable <= (state == LSF_SHUTDOWN) ? LSF_RST_ENABLE : next_enable;
			if (wr_level1) begin
				lvl1 <= bus.wdata[6:0];
			end
			if (wr_level2) begin
				lvl2 <= bus.wdata[6:0];
			end
			if (wr_imask) begin
				irq_mask <= bus.wdata[2:0];
			end
			str_flt <= next_str_flt;
			glb_flt <= (rd_glbflt ? 3'h0 : glb_flt) | glb_ev;
			// Set beats write-one-clear
			irq_stat[LSF_I_STR] <= (irq_stat[LSF_I_STR] & ~(wr_istat & bus.wdata[LSF_I_STR])) | (|deb_hit);
			irq_stat[LSF_I_GLB] <= (irq_stat[LSF_I_GLB] & ~(wr_istat & bus.wdata[LSF_I_GLB])) | glb_any;
			irq_stat[LSF_I_RUN] <= (irq_stat[LSF_I_RUN] & ~(wr_istat & bus.wdata[LSF_I_RUN]))
				| (state == LSF_STANDBY && next_state == LSF_ON);
		end
	end

	// Read mux
	logic [7:0] next_rdata;
	always_comb begin
		if (bus.addr == LSF_A_ENABLE) begin
			next_rdata = {3'h0, enable};
		end else if (bus.addr == LSF_A_LEVEL1) begin
			next_rdata = {1'b0, lvl1};
		end else if (bus.addr == LSF_A_LEVEL2) begin
			next_rdata = {1'b0, lvl2};
		end else if (bus.addr == LSF_A_STR_FLT) begin
			next_rdata = {3'h0, str_flt};
		end else if (bus.addr == LSF_A_GLB_FLT) begin
			next_rdata = {5'h00, glb_flt};
		end else if (bus.addr == LSF_A_STATE) begin
			next_rdata = {6'h00, state};
		end else if (bus.addr == LSF_A_IRQ_STAT) begin
			next_rdata = {5'h00, irq_stat};
		end else if (bus.addr == LSF_A_IRQ_MASK) begin
			next_rdata = {5'h00, irq_mask};
		end else if (bus.addr == LSF_A_CUR1) begin
			next_rdata = LSF_CUR_TAB[lvl1][11:4];
		end else if (bus.addr == LSF_A_CUR2) begin
			next_rdata = LSF_CUR_TAB[lvl2][11:4];
		end else begin
			next_rdata = 8'h00;
		end
	end

	wire conv = (state == LSF_ON);

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rdata <= 8'h00;
			converter_on <= 1'b0;
			soft_start <= 1'b0;
			string_on <= 5'h00;
			string_hiz <= 5'h1f;
			converter_switch_node_hiz <= 1'b1;
			level1 <= LSF_RST_LEVEL;
			level2 <= LSF_RST_LEVEL;
			power_state <= 2'b00;
			irq <= 1'b0;
		end else if (clk_en) begin
			rdata <= bus.rd ? next_rdata : 8'h00;
			converter_on <= conv;
			soft_start <= (state == LSF_STANDBY && next_state == LSF_ON);
			string_on <= conv ? enable : 5'h00;
			string_hiz <= conv ? 5'h00 : 5'h1f;
			converter_switch_node_hiz <= !conv;
			level1 <= lvl1;
			level2 <= lvl2;
			power_state <= state;
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Checks
	sequence s_fault_held;
		g_deb[0].flt && enable[0] && state == LSF_ON && clk_en;
	endsequence

	chk_standby_off: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && state != LSF_ON |=> converter_switch_node_hiz && string_hiz == 5'h1f)
		else $error("outputs not high impedance while converter off");
	chk_shutdown_reset: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && !supply_ok |=> state == LSF_SHUTDOWN && enable == 5'h00 && lvl1 == 7'h00)
		else $error("shutdown did not reset registers");
	chk_standby_entry: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && state == LSF_SHUTDOWN && supply_ok |=> state == LSF_STANDBY)
		else $error("standby not entered with supplies valid");
	chk_converter_start: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && state == LSF_STANDBY && |enable && !glb_block && supply_ok |=> state == LSF_ON)
		else $error("converter did not start on enable");
	chk_softstart_pulse: assert property (@(posedge mclk) disable iff (sys_rst)
		$rose(converter_on) |-> $past(soft_start, 1) || soft_start)
		else $error("soft start missing at converter turn on");
	chk_global_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && supply_ok && glb_any && state != LSF_SHUTDOWN |=> enable == 5'h00 && glb_flt != 3'h0)
		else $error("global fault did not clear enables");
	chk_strread_clear: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && supply_ok && rd_strflt && deb_hit == 5'h00 |=> str_flt == 5'h00)
		else $error("string fault flags not cleared by read");
	chk_debounce_latch: assert property (@(posedge mclk) disable iff (sys_rst)
		deb_hit[0] && clk_en && supply_ok |=> str_flt[0] && !enable[0])
		else $error("debounced fault not latched");
	chk_debounce_reset: assert property (@(posedge mclk) disable iff (sys_rst)
		s_fault_held ##1 (clk_en && !g_deb[0].flt) |=> g_deb[0].cnt == '0 && !deb_hit[0])
		else $error("debounce not restarted");
	chk_level_table: assert property (@(posedge mclk) disable iff (sys_rst)
		LSF_CUR_TAB[7'h00] == 12'd5 && LSF_CUR_TAB[7'h7f] == 12'd2525 && (lvl1 == 7'h00 || LSF_CUR_TAB[lvl1] > LSF_CUR_TAB[lvl1 - 7'h01]))
		else $error("level table not monotonic");
	chk_two_detectors: assert property (@(posedge mclk) disable iff (sys_rst)
		clk_en && state == LSF_ON && enable[0] && (sn.open_det[0] || sn.short_det[0]) && deb_hit[0] == 1'b0
		|=> g_deb[0].cnt != '0 || deb_hit[0] || !clk_en)
		else $error("open or short not seen by debounce");

endmodule

// ===== lsf_host.sv
/*
 Register bus master standing in for the serial host controller.
 Assumes a free-running mclk; the bench calls its tasks in sequence.
*/
`timescale 1ns/1ps
module lsf_host
	import lsf_pkg::*;
(
	// Clock
	input  wire logic mclk,
	// Register port
	output lsf_bus_t  bus
);
	initial bus = '0;

	// One-cycle write strobe, data inverted once released
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk);
		bus <= '{addr: a, wdata: ~d, wr: 1'b0, rd: 1'b0};
	endtask

	// Fault flags clear on read, so the host reads them before re-enabling
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'hff, wr: 1'b0, rd: 1'b1};
		@(posedge mclk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
	endtask
endmodule

// ===== led_driver_state_fault_control_bench.sv
/*
 Self-checking bench for the state and fault controller.
 Assumes a short debounce parameter; sense inputs driven on mclk edges.
*/
`timescale 1ns/1ps
module led_driver_state_fault_control_bench;
	import lsf_pkg::*;
	localparam int DEB = 8;
	logic       mclk;
	logic       sys_rst;
	lsf_bus_t   bus;
	lsf_sense_t sense;
	logic [7:0] rdata;
	logic       converter_on, soft_start, sw_hiz, irq;
	logic [4:0] string_on, string_hiz;
	logic [6:0] level1, level2, code;
	logic [1:0] power_state;
	logic [7:0] exp_q [$];
	logic       rd_d = 1'b0;
	int         num_errors = 0;
	int         check_count = 0;
	int         starts = 0;
	int         seed;

	lsf_ctrl #(.DEB_CYC(DEB)) u_lsf_ctrl (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1), .bus(bus),
		.rdata(rdata), .sense(sense), .converter_on(converter_on), .soft_start(soft_start),
		.string_on(string_on), .string_hiz(string_hiz), .converter_switch_node_hiz(sw_hiz),
		.level1(level1), .level2(level2), .power_state(power_state), .irq(irq));
	lsf_host u_lsf_host (.mclk(mclk), .bus(bus));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask

	// Read data stand only in the cycle after the strobe
	always @(posedge mclk) begin
		if (rd_d)
			chk("rdata", (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx, rdata);
		rd_d <= bus.rd;
		if (soft_start === 1'b1)
			starts <= starts + 1;
	end

	task automatic rdc(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_lsf_host.rd(a);
	endtask

	function automatic logic [7:0] probe(input int s);
		case (s)
			0: probe = {6'h00, power_state};
			1: probe = {3'h0, string_on};
			2: probe = {7'h00, irq};
			default: probe = {3'h0, string_hiz};
		endcase
	endfunction

	// Bounded wait, sampled away from the driving edge
	task automatic await(input int s, input logic [7:0] e);
		for (int i = 0; i < 64 && probe(s) !== e; i++)
			@(negedge mclk);
		chk($sformatf("probe %0d", s), e, probe(s));
	endtask

	task automatic close_out;
		$display("checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge mclk);
		num_errors++;
		close_out;
	end

	initial begin
		seed = 48;
		sys_rst = 1'b1;
		sense = '0;
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		await(0, {6'h00, LSF_SHUTDOWN});
		await(3, 8'h1f);
		u_lsf_host.wr(LSF_A_LEVEL1, 8'h2a);
		rdc(LSF_A_LEVEL1, 8'h00);
		@(posedge mclk);
		sense.vdd_ok <= 1'b1;
		sense.vin_ok <= 1'b1;
		await(0, {6'h00, LSF_STANDBY});
		chk("converter_on", 8'h00, {7'h00, converter_on});
		chk("switch_hiz", 8'h01, {7'h00, sw_hiz});
		for (int c = 0; c < 128; c++) begin
			u_lsf_host.wr(LSF_A_LEVEL1, 8'(c));
			rdc(LSF_A_CUR1, LSF_CUR_TAB[c][11:4]);
		end
		repeat (4) begin
			code = 7'($random(seed));
			u_lsf_host.wr(LSF_A_LEVEL2, {1'b0, code});
			rdc(LSF_A_LEVEL2, {1'b0, code});
			rdc(LSF_A_CUR2, LSF_CUR_TAB[code][11:4]);
		end
		u_lsf_host.wr(LSF_A_ENABLE, 8'h01);
		await(0, {6'h00, LSF_ON});
		await(1, 8'h01);
		chk("converter_on", 8'h01, {7'h00, converter_on});
		chk("starts", 8'h01, 8'(starts));
		chk("switch_hiz", 8'h00, {7'h00, sw_hiz});
		u_lsf_host.wr(LSF_A_IRQ_STAT, 8'h04);
		await(2, 8'h00);
		// Two short glitches; a timer that never restarts would latch
		repeat (2) begin
			@(posedge mclk);
			sense.open_det[0] <= 1'b1;
			repeat (5) @(posedge mclk);
			sense.open_det[0] <= 1'b0;
			repeat (2) @(posedge mclk);
		end
		repeat (20) @(negedge mclk);
		chk("string_on", 8'h01, {3'h0, string_on});
		rdc(LSF_A_STR_FLT, 8'h00);
		@(posedge mclk);
		sense.open_det[0] <= 1'b1;
		repeat (6) @(negedge mclk);
		chk("string_on", 8'h01, {3'h0, string_on});
		await(1, 8'h00);
		// Mask bit high lets the status bit through
		u_lsf_host.wr(LSF_A_IRQ_MASK, 8'h01);
		await(2, 8'h01);
		u_lsf_host.wr(LSF_A_IRQ_MASK, 8'h00);
		await(2, 8'h00);
		u_lsf_host.wr(LSF_A_IRQ_MASK, 8'h01);
		await(2, 8'h01);
		u_lsf_host.wr(LSF_A_IRQ_STAT, 8'h01);
		await(2, 8'h00);
		sense.open_det[0] <= 1'b0;
		repeat (6) @(posedge mclk);
		rdc(LSF_A_STR_FLT, 8'h01);
		await(1, 8'h01);
		sense.short_det[0] <= 1'b1;
		await(1, 8'h00);
		sense.short_det[0] <= 1'b0;
		repeat (6) @(posedge mclk);
		rdc(LSF_A_STR_FLT, 8'h01);
		await(1, 8'h01);
		for (int b = 0; b < 3; b++) begin
			@(posedge mclk);
			sense[4 - b] <= 1'b1;
			await(0, {6'h00, LSF_STANDBY});
			sense[4 - b] <= 1'b0;
			rdc(LSF_A_ENABLE, 8'h00);
			u_lsf_host.wr(LSF_A_ENABLE, 8'h01);
			repeat (8) @(negedge mclk);
			chk("refused", {6'h00, LSF_STANDBY}, {6'h00, power_state});
			rdc(LSF_A_GLB_FLT, 8'h01 << b);
			u_lsf_host.wr(LSF_A_ENABLE, 8'h01);
			await(0, {6'h00, LSF_ON});
		end
		@(posedge mclk);
		sense.vdd_ok <= 1'b0;
		await(0, {6'h00, LSF_SHUTDOWN});
		await(3, 8'h1f);
		chk("level1", 8'h00, {1'b0, level1});
		repeat (4) @(posedge mclk);
		chk("queue", 8'h00, 8'(exp_q.size()));
		close_out;
	end
endmodule
